// ===== rtl/piw_pkg.sv
// Shared constants and types of the pin interrupt and wake-up controller.
// Assumes registers sit at word index times four on a 32-bit APB bus.
package piw_pkg;
   // ****************************************************************
   // Register indices; byte address is four times the index.
   // ****************************************************************
   localparam logic [9:0] IDX_POWER_CTRL = 10'h087;
   localparam logic [9:0] IDX_TIMER_EXT  = 10'h088;
   localparam logic [9:0] IDX_AUX_FLAGS  = 10'h095;
   localparam logic [9:0] IDX_IRQ_EN0    = 10'h0a8;
   localparam logic [9:0] IDX_IRQ_EN1    = 10'h0a9;
   localparam logic [9:0] IDX_WAKE0      = 10'h0c5;
   localparam logic [9:0] IDX_WAKE1      = 10'h096;
   localparam logic [9:0] IDX_WAKE2      = 10'h0c6;
   localparam logic [9:0] IDX_WAKE3      = 10'h0c7;
   // ****************************************************************
   // Field positions, masks and reset values.
   // ****************************************************************
   localparam int POS_STOP_REQ   = 1;
   localparam int POS_SLEEP_REQ  = 0;
   localparam int POS_EXT1_FLAG  = 3;
   localparam int POS_EXT1_TRIG  = 2;
   localparam int POS_EXT0_FLAG  = 1;
   localparam int POS_EXT0_TRIG  = 0;
   localparam int POS_EXT2_FLAG  = 2;
   localparam int POS_PORT_FLAG  = 1;
   localparam int POS_GLOBAL_EN  = 7;
   localparam int POS_EXT1_EN    = 2;
   localparam int POS_EXT0_EN    = 0;
   localparam int POS_EXT2_EN    = 2;
   localparam int POS_PORT_EN    = 1;
   localparam logic [7:0] MASK_POWER_KEEP = 8'h8c;
   localparam logic [7:0] MASK_TIMER_KEEP = 8'hf0;
   localparam logic [7:0] MASK_EN0        = 8'hbf;
   localparam logic [7:0] MASK_EN1        = 8'hbf;
   localparam logic [7:0] RST_BYTE        = 8'h00;
   localparam logic [31:0] RST_WORD       = 32'h0000_0000;
   localparam int unsigned WARM_CYC_DEF   = 16;
   // ****************************************************************
   // Types.
   // ****************************************************************
   typedef struct packed {
      logic port;
      logic ext2;
      logic ext1;
      logic ext0;
   } piw_src_t;
   typedef enum logic [1:0] {MODE_RUN, MODE_IDLE, MODE_STOP, MODE_WARM}
      piw_mode_t;
endpackage : piw_pkg

// ===== rtl/piw_ctrl.sv
// Pin interrupt capture, Idle and Stop mode control, APB register slave.
// Assumes the core acknowledges a vectored source with a one-cycle pulse
// and that the clock keeps running; Stop freezes pin edge sampling and withholds requests.
//
// Functional notes
// - pins 0,1 low level or falling edge
// - pin 1 edge sets flag regardless enable
// - pin 0 edge sets flag regardless enable
// - vectoring to service clears its flag
// - pin 2 falling edge only, flag
// - writing FBh clears pin 2 flag
// - masked port change sets port flag
// - writing FDh clears port flag
// - aux flag: 0 clears, 1 no effect
// - no Stop while enabled pin low
// - Idle wakes on enabled, globally enabled interrupt
// - core services first, then resumes after Idle
// - stop request bit enters Stop
// - sleep request bit enters Idle
// - pin enable alone gives Stop wake
// - port wake mask gives Stop wake
// - core resumes instruction before servicing after Stop
// - post-Stop service needs enables and sampled trigger
// - port change either direction raises request
// - port change unsampled; pin 0 after warm-up
// - global enable gates all, then individual enables
// - port enable gates service, not wake
// - four 8-bit wake masks, reset zero
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module piw_ctrl
   import piw_pkg::*;
#(
   parameter int unsigned WARM_CYC = piw_pkg::WARM_CYC_DEF
) (
   input  wire  logic              sys_clk,
   input  wire  logic              resetn,
   input  wire  logic              psel,
   input  wire  logic              penable,
   input  wire  logic              pwrite,
   input  wire  logic [11:0]       paddr,
   input  wire  logic [31:0]       pwdata,
   output var   logic [31:0]       prdata,
   output var   logic              pready,
   output var   logic              pslverr,
   input  wire  logic [2:0]        extPin,
   input  wire  logic [31:0]       portPin,
   input  wire  piw_pkg::piw_src_t irqAck,
   output var   piw_pkg::piw_src_t irqReq,
   output var   logic              idleMode,
   output var   logic              stopMode
);
   import piw_pkg::*;

   // ****************************************************************
   // Pin synchronisers and edge detection.
   // ****************************************************************
   logic [2:0]  extMeta_q, extSync_q, extPrev_q;
   logic [31:0] portMeta_q, portSync_q, portPrev_q;
   piw_mode_t   mode_q;
   logic        sampleOn;
   logic [2:0]  extFall;
   logic [31:0] wakeMask;
   logic        portChg;

   // Pin edges are frozen during Stop and warm-up, so a pulse that ends
   // before the oscillator settles wakes the chip but is never serviced.
   assign sampleOn = (mode_q != MODE_STOP) && (mode_q != MODE_WARM);
   assign extFall  = extPrev_q & ~extSync_q & {3{sampleOn}};

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         extMeta_q  <= 3'h7;
         extSync_q  <= 3'h7;
         extPrev_q  <= 3'h7;
         portMeta_q <= RST_WORD;
         portSync_q <= RST_WORD;
         portPrev_q <= RST_WORD;
      end else begin
         extMeta_q  <= extPin;
         extSync_q  <= extMeta_q;
         portMeta_q <= portPin;
         portSync_q <= portMeta_q;
         portPrev_q <= portSync_q;
         if (sampleOn) begin
            extPrev_q <= extSync_q;
         end
      end
   end

   // Any direction of change on a masked pin counts.
   assign portChg = |((portSync_q ^ portPrev_q) & wakeMask);

   // ****************************************************************
   // APB slave: no wait states, answer registered at setup.
   // ****************************************************************
   logic [7:0] powerKeep_q, timerKeep_q, en0_q, en1_q;
   logic [7:0] wake_q [4];
   logic       ext0Flag_q, ext1Flag_q, ext2Flag_q, portFlag_q;
   logic       wrEn;
   logic [9:0] idx;
   logic [7:0] rdByte, wb;
   logic       hit;

   assign idx  = paddr[11:2];
   assign wb   = pwdata[7:0];
   assign wrEn = psel & penable & pready & pwrite;
   assign wakeMask = {wake_q[3], wake_q[2], wake_q[1], wake_q[0]};

   always_comb begin
      rdByte = RST_BYTE;
      hit    = 1'b1;
      case (idx)
         IDX_POWER_CTRL: begin
            rdByte = powerKeep_q;
            rdByte[POS_STOP_REQ]  = stopMode;
            rdByte[POS_SLEEP_REQ] = idleMode;
         end
         IDX_TIMER_EXT: begin
            rdByte = timerKeep_q;
            rdByte[POS_EXT1_FLAG] = ext1Flag_q;
            rdByte[POS_EXT0_FLAG] = ext0Flag_q;
         end
         IDX_AUX_FLAGS: begin
            rdByte[POS_EXT2_FLAG] = ext2Flag_q;
            rdByte[POS_PORT_FLAG] = portFlag_q;
         end
         IDX_IRQ_EN0: rdByte = en0_q;
         IDX_IRQ_EN1: rdByte = en1_q;
         IDX_WAKE0:   rdByte = wake_q[0];
         IDX_WAKE1:   rdByte = wake_q[1];
         IDX_WAKE2:   rdByte = wake_q[2];
         IDX_WAKE3:   rdByte = wake_q[3];
         default:     hit = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= RST_WORD;
      end else begin
         pready  <= psel & ~penable & ~pready;
         if (psel && !penable) begin
            pslverr <= ~hit;
            prdata  <= {24'h00_0000, rdByte};
         end
      end
   end

   // ****************************************************************
   // Plain control registers.
   // ****************************************************************
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         powerKeep_q <= RST_BYTE;
         timerKeep_q <= RST_BYTE;
         en0_q       <= RST_BYTE;
         en1_q       <= RST_BYTE;
         for (int i = 0; i < 4; i++) begin
            wake_q[i] <= RST_BYTE;
         end
      end else if (wrEn) begin
         case (idx)
            IDX_POWER_CTRL: powerKeep_q <= wb & MASK_POWER_KEEP;
            IDX_TIMER_EXT:  timerKeep_q <= wb & ~{4'h0,
               1'b1, 1'b0, 1'b1, 1'b0};
            IDX_IRQ_EN0:    en0_q <= wb & MASK_EN0;
            IDX_IRQ_EN1:    en1_q <= wb & MASK_EN1;
            IDX_WAKE0:      wake_q[0] <= wb;
            IDX_WAKE1:      wake_q[1] <= wb;
            IDX_WAKE2:      wake_q[2] <= wb;
            IDX_WAKE3:      wake_q[3] <= wb;
            default: begin
            end
         endcase
      end
   end

   // ****************************************************************
   // Request flags; a hardware set always beats any clear.
   // ****************************************************************
   logic trig0, trig1, wrTimer, wrAux, globalEn;
   assign trig0    = timerKeep_q[POS_EXT0_TRIG];
   assign trig1    = timerKeep_q[POS_EXT1_TRIG];
   assign wrTimer  = wrEn && (idx == IDX_TIMER_EXT);
   assign wrAux    = wrEn && (idx == IDX_AUX_FLAGS);
   assign globalEn = en0_q[POS_GLOBAL_EN];

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ext0Flag_q <= 1'b0;
         ext1Flag_q <= 1'b0;
      end else begin
         if (!trig0) begin
            ext0Flag_q <= ~extSync_q[0] & sampleOn;
         end else if (extFall[0]) begin
            ext0Flag_q <= 1'b1;
         end else if (irqAck.ext0) begin
            ext0Flag_q <= 1'b0;
         end else if (wrTimer) begin
            ext0Flag_q <= wb[POS_EXT0_FLAG];
         end
         if (!trig1) begin
            ext1Flag_q <= ~extSync_q[1] & sampleOn;
         end else if (extFall[1]) begin
            ext1Flag_q <= 1'b1;
         end else if (irqAck.ext1) begin
            ext1Flag_q <= 1'b0;
         end else if (wrTimer) begin
            ext1Flag_q <= wb[POS_EXT1_FLAG];
         end
      end
   end

   // Writing 0 clears an aux flag and writing 1 leaves it, which gives
   // the FBh and FDh single-flag clears without a read-modify-write.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ext2Flag_q <= 1'b0;
         portFlag_q <= 1'b0;
      end else begin
         if (extFall[2]) begin
            ext2Flag_q <= 1'b1;
         end else if (irqAck.ext2 ||
                      (wrAux && !wb[POS_EXT2_FLAG])) begin
            ext2Flag_q <= 1'b0;
         end
         if (portChg) begin
            portFlag_q <= 1'b1;
         end else if (irqAck.port ||
                      (wrAux && !wb[POS_PORT_FLAG])) begin
            portFlag_q <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Interrupt gating and power modes.
   // ****************************************************************
   piw_src_t   srcEn, srcPend, srcLive;
   logic       extLowEn, stopWake;
   logic [$clog2(WARM_CYC+1)-1:0] warmCnt_q;

   assign srcEn = '{port: en1_q[POS_PORT_EN], ext2: en1_q[POS_EXT2_EN],
                    ext1: en0_q[POS_EXT1_EN], ext0: en0_q[POS_EXT0_EN]};
   assign srcPend = '{port: portFlag_q, ext2: ext2Flag_q,
                      ext1: ext1Flag_q, ext0: ext0Flag_q};
   assign srcLive = srcPend & srcEn & {4{globalEn}};
   assign extLowEn = |(~extSync_q &
                       {srcEn.ext2, srcEn.ext1, srcEn.ext0});
   // Port wake ignores the port interrupt enable.
   assign stopWake = extLowEn | portChg;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mode_q    <= MODE_RUN;
         warmCnt_q <= '0;
      end else begin
         case (mode_q)
            MODE_RUN: begin
               if (wrEn && idx == IDX_POWER_CTRL) begin
                  if (wb[POS_STOP_REQ] && !extLowEn) begin
                     mode_q <= MODE_STOP;
                  end else if (wb[POS_SLEEP_REQ]) begin
                     mode_q <= MODE_IDLE;
                  end
               end
            end
            MODE_IDLE: begin
               if (|srcLive) begin
                  mode_q <= MODE_RUN;
               end
            end
            MODE_STOP: begin
               if (stopWake) begin
                  mode_q    <= MODE_WARM;
                  warmCnt_q <= ($clog2(WARM_CYC+1))'(WARM_CYC);
               end
            end
            MODE_WARM: begin
               if (warmCnt_q <= 1) begin
                  mode_q <= MODE_RUN;
               end
               warmCnt_q <= warmCnt_q - 1'b1;
            end
            default: mode_q <= MODE_RUN;
         endcase
      end
   end

   // Requests are withheld in Stop and warm-up; the core then finishes
   // the instruction after the stop write before it vectors.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         irqReq   <= '0;
         idleMode <= 1'b0;
         stopMode <= 1'b0;
      end else begin
         irqReq   <= sampleOn ? srcLive : '0;
         idleMode <= (mode_q == MODE_IDLE);
         stopMode <= (mode_q == MODE_STOP) || (mode_q == MODE_WARM);
      end
   end

   // ****************************************************************
   // Checks.
   // ****************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   a_ext1_edge_set: assert property (
      trig1 && extFall[1] |=> ext1Flag_q)
      else $error("Pin 1 edge did not set its flag.");
   a_ext0_edge_set: assert property (
      trig0 && extFall[0] |=> ext0Flag_q)
      else $error("Pin 0 edge did not set its flag.");
   a_ext2_edge_set: assert property (
      extFall[2] |=> ext2Flag_q)
      else $error("Pin 2 edge did not set its flag.");
   a_ack_clears_flag: assert property (
      irqAck.ext2 && !extFall[2] |=> !ext2Flag_q)
      else $error("Acknowledge did not clear pin 2 flag.");
   a_fb_clears_ext2: assert property (
      wrAux && wb == 8'hfb && !extFall[2] && !portChg && portFlag_q &&
      !irqAck.port |=> !ext2Flag_q && portFlag_q)
      else $error("Write FBh misbehaved.");
   a_fd_clears_port: assert property (
      wrAux && wb == 8'hfd && !portChg && !extFall[2] && ext2Flag_q &&
      !irqAck.ext2 |=> !portFlag_q && ext2Flag_q)
      else $error("Write FDh misbehaved.");
   a_aux_one_keeps: assert property (
      wrAux && wb == 8'hff && portFlag_q && !irqAck.port |=> portFlag_q)
      else $error("Writing one cleared an aux flag.");
   a_stop_refused: assert property (
      mode_q == MODE_RUN && wrEn && idx == IDX_POWER_CTRL &&
      wb[POS_STOP_REQ] && extLowEn |=> ##1 !stopMode)
      else $error("Stop entered with enabled pin low.");
   a_idle_needs_ea: assert property (
      mode_q == MODE_IDLE && !globalEn |=> mode_q == MODE_IDLE)
      else $error("Idle left without global enable.");
   a_level_follows: assert property (
      !trig0 && sampleOn && $rose(extSync_q[0]) |=> !ext0Flag_q)
      else $error("Level request latched after pin rose.");

   c_stop_wake: cover property (
      mode_q == MODE_STOP ##1 mode_q == MODE_WARM);
   c_idle_wake: cover property (
      mode_q == MODE_IDLE ##1 mode_q == MODE_RUN);
   c_port_irq: cover property (irqReq.port);
endmodule : piw_ctrl
`default_nettype wire

// ===== testbench/piw_core_model.sv
// Behavioural model of the processor core that vectors pending sources.
// Assumes irqReq is a level from the controller that drops after the ack.
`timescale 1ns/1ps
`default_nettype none
module piw_core_model
   import piw_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   input  wire piw_pkg::piw_src_t irqReq,
   input  wire logic              ackEn,
   input  wire logic [3:0]        ackDelay,
   output var  piw_pkg::piw_src_t irqAck
);
   logic [3:0] reqBits;
   logic [3:0] waitQ;
   logic [1:0] gapQ;

   assign reqBits = irqReq;

   // The gap lets a serviced request fall before the next one is vectored,
   // otherwise the same source would be acknowledged twice.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         irqAck <= '0;
         waitQ  <= 4'h0;
         gapQ   <= 2'h0;
      end else begin
         irqAck <= '0;
         if (gapQ != 2'h0) begin
            gapQ <= gapQ - 2'h1;
         end else if (ackEn && reqBits != 4'h0) begin
            if (waitQ >= ackDelay) begin
               irqAck <= piw_src_t'(reqBits & (~reqBits + 4'h1));
               waitQ  <= 4'h0;
               gapQ   <= 2'h3;
            end else begin
               waitQ <= waitQ + 4'h1;
            end
         end else begin
            waitQ <= 4'h0;
         end
      end
   end
endmodule : piw_core_model
`default_nettype wire

// ===== testbench/pin_interrupt_wakeup_ctrl_test.sv
// Self-checking bench of the pin interrupt and wake-up controller.
// Assumes the APB slave answers with one access cycle and a core model.
`timescale 1ns/1ps
`default_nettype none
module pin_interrupt_wakeup_ctrl_test;
   import piw_pkg::*;
   logic              sys_clk;
   logic              resetn;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [11:0]       paddr;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic [2:0]        extPin;
   logic [31:0]       portPin;
   piw_src_t          irqAck;
   piw_src_t          irqReq;
   logic              idleMode;
   logic              stopMode;
   logic              ackEn;
   logic [3:0]        ackDelay;
   int                errorCnt;
   int                totalChecks;

   piw_ctrl #(.WARM_CYC(2)) u_piw_ctrl (.sys_clk(sys_clk), .resetn(resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .extPin(extPin), .portPin(portPin), .irqAck(irqAck), .irqReq(irqReq),
      .idleMode(idleMode), .stopMode(stopMode));

   piw_core_model u_piw_core_model (.sys_clk(sys_clk), .resetn(resetn),
      .irqReq(irqReq), .ackEn(ackEn), .ackDelay(ackDelay), .irqAck(irqAck));

   initial sys_clk = 1'b0;
   always #2.5 sys_clk = ~sys_clk;

   // ****************************************************************
   // Tasks.
   // ****************************************************************
   task automatic conclude;
      $display("checks=%0d errors=%0d", totalChecks, errorCnt);
      if (errorCnt == 0 && totalChecks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         errorCnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // One bus transfer; the request stands until pready is sampled high.
   task automatic xfer(input logic wr, input logic [9:0] idx,
                       input logic [7:0] wd, output logic [31:0] rd,
                       output logic err);
      int n;
      @(posedge sys_clk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= {24'h0, wd};
      @(posedge sys_clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge sys_clk);
         if (pready === 1'b1) break;
      end
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n == 20) begin
         errorCnt++;
         conclude();
      end
   endtask : xfer

   task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
      logic [31:0] d;
      logic        e;
      xfer(1'b1, idx, wd, d, e);
   endtask : wr

   task automatic rdChk(input logic [9:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      logic        e;
      xfer(1'b0, idx, 8'h00, d, e);
      chk(d, exp);
   endtask : rdChk

   // Pins pass a two-stage synchroniser and a flag stage before showing.
   task automatic settle;
      repeat (6) @(posedge sys_clk);
   endtask : settle

   task automatic waitMode(input logic stop, input logic val);
      int n;
      for (n = 0; n < 60; n++) begin
         @(posedge sys_clk);
         if ((stop ? stopMode : idleMode) === val) break;
      end
      chk({31'h0, stop ? stopMode : idleMode}, {31'h0, val});
      if (n == 60) conclude();
   endtask : waitMode

   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial begin
      logic [31:0] d;
      logic        e;
      errorCnt = 0;
      totalChecks = 0;
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      extPin = 3'h7;
      portPin = 32'h0;
      ackEn = 1'b0;
      ackDelay = 4'h3;
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      rdChk(IDX_TIMER_EXT, 32'h00);
      rdChk(IDX_AUX_FLAGS, 32'h00);
      rdChk(IDX_POWER_CTRL, 32'h00);
      rdChk(IDX_WAKE0, 32'h00);
      rdChk(IDX_WAKE1, 32'h00);
      rdChk(IDX_WAKE2, 32'h00);
      rdChk(IDX_WAKE3, 32'h00);
      xfer(1'b0, 10'h000, 8'h00, d, e);
      chk({31'h0, e}, 32'h1);
      // Edge flags set with every individual enable still off.
      wr(IDX_TIMER_EXT, 8'h05);
      extPin <= 3'h0;
      settle();
      rdChk(IDX_TIMER_EXT, 32'h0f);
      rdChk(IDX_AUX_FLAGS, 32'h04);
      chk({28'h0, irqReq}, 32'h0);
      wr(IDX_AUX_FLAGS, 8'hff);
      rdChk(IDX_AUX_FLAGS, 32'h04);
      wr(IDX_AUX_FLAGS, 8'hfb);
      rdChk(IDX_AUX_FLAGS, 32'h00);
      extPin <= 3'h7;
      wr(IDX_IRQ_EN0, 8'h81);
      settle();
      chk({28'h0, irqReq}, 32'h1);
      ackEn <= 1'b1;
      repeat (12) @(posedge sys_clk);
      rdChk(IDX_TIMER_EXT, 32'h0d);
      ackEn <= 1'b0;
      // Level mode on pins 0 and 1: the flags follow the pins, not held.
      wr(IDX_TIMER_EXT, 8'h00);
      rdChk(IDX_TIMER_EXT, 32'h00);
      extPin <= 3'h4;
      settle();
      rdChk(IDX_TIMER_EXT, 32'h0a);
      extPin <= 3'h7;
      settle();
      rdChk(IDX_TIMER_EXT, 32'h00);
      // Port change in both directions, masked and unmasked pins.
      wr(IDX_WAKE0, 8'h01);
      portPin <= 32'h1;
      settle();
      rdChk(IDX_AUX_FLAGS, 32'h02);
      wr(IDX_AUX_FLAGS, 8'hff);
      rdChk(IDX_AUX_FLAGS, 32'h02);
      wr(IDX_AUX_FLAGS, 8'hfd);
      rdChk(IDX_AUX_FLAGS, 32'h00);
      portPin <= 32'h0;
      settle();
      rdChk(IDX_AUX_FLAGS, 32'h02);
      wr(IDX_AUX_FLAGS, 8'hfd);
      portPin <= 32'h2;
      settle();
      rdChk(IDX_AUX_FLAGS, 32'h00);
      // Stop refused while an enabled pin is low, then entered and left.
      extPin <= 3'h6;
      settle();
      wr(IDX_POWER_CTRL, 8'h02);
      repeat (4) @(posedge sys_clk);
      chk({31'h0, stopMode}, 32'h0);
      extPin <= 3'h7;
      wr(IDX_IRQ_EN0, 8'h01);
      settle();
      wr(IDX_POWER_CTRL, 8'h02);
      waitMode(1'b1, 1'b1);
      extPin <= 3'h6;
      waitMode(1'b1, 1'b0);
      chk({28'h0, irqReq}, 32'h0);
      extPin <= 3'h7;
      settle();
      // Port wake with the port interrupt enable left off.
      wr(IDX_POWER_CTRL, 8'h02);
      waitMode(1'b1, 1'b1);
      portPin <= 32'h3;
      waitMode(1'b1, 1'b0);
      rdChk(IDX_AUX_FLAGS, 32'h02);
      // Idle needs both the individual and the global enable.
      wr(IDX_IRQ_EN1, 8'h04);
      wr(IDX_IRQ_EN0, 8'h00);
      wr(IDX_POWER_CTRL, 8'h01);
      waitMode(1'b0, 1'b1);
      extPin <= 3'h3;
      settle();
      chk({31'h0, idleMode}, 32'h1);
      chk({28'h0, irqReq}, 32'h0);
      wr(IDX_IRQ_EN0, 8'h80);
      waitMode(1'b0, 1'b0);
      chk({28'h0, irqReq}, 32'h4);
      // Single-flag clears with both aux flags set, then a vectored clear.
      rdChk(IDX_AUX_FLAGS, 32'h06);
      wr(IDX_AUX_FLAGS, 8'hfb);
      rdChk(IDX_AUX_FLAGS, 32'h02);
      extPin <= 3'h7;
      settle();
      extPin <= 3'h3;
      settle();
      wr(IDX_AUX_FLAGS, 8'hfd);
      rdChk(IDX_AUX_FLAGS, 32'h04);
      ackEn <= 1'b1;
      repeat (12) @(posedge sys_clk);
      rdChk(IDX_AUX_FLAGS, 32'h00);
      conclude();
   end
endmodule : pin_interrupt_wakeup_ctrl_test
`default_nettype wire
